// ===== scrc_core.sv
// scrc_core.sv - subroutine call, entry and return sequencer for one task
`timescale 1ns/10ps
module scrc_core
	import scrc_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic              i_task_start,
	input  wire logic [TASK_W-1:0] i_task_id,
	input  wire logic              i_scan_start,
	input  wire logic              i_instr_valid,
	input  wire logic [FC_W-1:0]   i_instr_fc,
	input  wire logic [SUBN_W-1:0] i_instr_subn,
	input  wire logic [EDGE_W-1:0] i_instr_edge,
	input  wire logic              i_instr_cond,
	input  wire logic              i_interlock,
	input  wire logic              i_def_valid,
	input  wire logic [SUBN_W-1:0] i_def_subn,
	input  wire logic [TASK_W-1:0] i_def_task,
	input  wire logic [PC_W-1:0]   i_def_pc,
	output logic                   o_instr_ready,
	output logic [PC_W-1:0]        o_pc,
	output logic                   o_error_flag,
	output logic [SP_W-1:0]        o_depth,
	output logic                   o_in_sub,
	output logic [NUM_EDGE-1:0]    o_edge_out
);
	scrc_stack_if st();

	scrc_state_t         state_q;
	logic [PC_W-1:0]     pc_q;
	logic                err_q;
	logic [PC_W-1:0]     entry_pc_q [NUM_SUBS];
	logic [TASK_W-1:0]   entry_task_q [NUM_SUBS];
	logic [NUM_SUBS-1:0] defined_q;
	logic [NUM_SUBS-1:0] ran_q;
	logic [NUM_EDGE-1:0] edge_q;
	logic [NUM_EDGE-1:0] prev_in_q;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic is_fc(input logic [FC_W-1:0] fc, input logic [FC_W-1:0] ref_fc);
		return fc == ref_fc;
	endfunction

	function automatic logic [PC_W-1:0] next_pc(input logic [PC_W-1:0] pc);
		return pc + 16'h0001;
	endfunction

	logic take;
	logic do_call;
	logic do_ret;
	logic do_entry;
	logic is_edge;
	logic in_sub;
	logic call_err;
	logic subn_ok;

	// a restart edge takes no instruction, so no flag or edge output moves then
	assign take     = i_instr_valid && state_q == SCRC_MAIN && !i_task_start;
	assign in_sub   = st.depth != SP_EMPTY;
	// call taken unless interlocked, which turns it into no-operation
	assign do_call  = take && is_fc(i_instr_fc, FC_SUB_CALL) && !i_interlock;
	assign do_ret   = take && is_fc(i_instr_fc, FC_SUB_RETURN);
	assign do_entry = take && is_fc(i_instr_fc, FC_SUB_ENTRY);
	assign is_edge  = take && (is_fc(i_instr_fc, FC_RISE_EDGE) || is_fc(i_instr_fc, FC_FALL_EDGE));
	assign subn_ok  = i_instr_subn <= SUBN_MAX;

	// error conditions of a call, checked together
	assign call_err = !subn_ok
		|| st.depth == SP_FULL
		|| !defined_q[i_instr_subn]
		|| st.active[i_instr_subn]
		|| entry_task_q[i_instr_subn] != i_task_id;

	assign o_instr_ready = state_q == SCRC_MAIN;

	// ------------------------------------------------------------
	// entry-marker directory, loaded while a task program is scanned in
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			defined_q <= '0;
		end else if (i_def_valid) begin
			defined_q[i_def_subn] <= 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_def_valid) begin
			entry_pc_q[i_def_subn]   <= i_def_pc;
			entry_task_q[i_def_subn] <= i_def_task;
		end
	end

	// ------------------------------------------------------------
	// sequencer state
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_q <= SCRC_IDLE;
		end else if (i_task_start) begin
			state_q <= SCRC_MAIN;
		end else begin
			case (state_q)
				SCRC_IDLE: state_q <= SCRC_IDLE;
				// entry marker reached in sequence ends the main program
				SCRC_MAIN: begin
					if (do_entry && !in_sub) begin
						state_q <= SCRC_DONE;
					end
				end
				SCRC_DONE: state_q <= SCRC_DONE;
				default:   state_q <= SCRC_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// program counter
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pc_q <= PC_RESET;
		end else if (i_task_start) begin
			pc_q <= PC_RESET;
		end else if (do_call && !call_err) begin
			pc_q <= next_pc(entry_pc_q[i_instr_subn]);
		end else if (do_ret && in_sub) begin
			pc_q <= st.top.ret_pc;
		end else if (take) begin
			pc_q <= next_pc(pc_q);
		end
	end

	// return stack control
	always_comb begin
		st.push       = do_call && !call_err;
		st.pop        = do_ret && in_sub;
		st.clear      = i_task_start;
		st.wdata.ret_pc = next_pc(pc_q);
		st.wdata.subn   = i_instr_subn;
	end

	// ------------------------------------------------------------
	// error flag: only a taken call writes it
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			err_q <= 1'b0;
		end else if (do_call) begin
			err_q <= call_err;
		end
		// entry and return leave the flag alone
	end

	// ------------------------------------------------------------
	// per-scan run tracking and edge-detect outputs
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst || i_scan_start) begin
			ran_q <= '0;
		end else if (st.push) begin
			ran_q[i_instr_subn] <= 1'b1;
		end
	end

	// set when a call re-enters a subroutine already run in this scan
	logic [NUM_SUBS-1:0] twice_q;
	always_ff @(posedge i_clk) begin
		if (i_rst || i_scan_start) begin
			twice_q <= '0;
		end else if (st.push && ran_q[i_instr_subn]) begin
			twice_q[i_instr_subn] <= 1'b1;
		end
	end

	// pass state follows the top frame, so a nested callee keeps its own record
	logic second_pass;
	logic edge_fire;
	assign second_pass = in_sub && twice_q[st.top.subn];
	assign edge_fire = is_fc(i_instr_fc, FC_RISE_EDGE)
		? (i_instr_cond && !prev_in_q[i_instr_edge])
		: (!i_instr_cond && prev_in_q[i_instr_edge]);

	// second pass forces off unsampled; untouched outputs hold
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			edge_q    <= '0;
			prev_in_q <= '0;
		end else if (is_edge) begin
			if (second_pass) begin
				edge_q[i_instr_edge] <= 1'b0;
			end else begin
				edge_q[i_instr_edge]    <= edge_fire;
				prev_in_q[i_instr_edge] <= i_instr_cond;
			end
		end
		// no call means no write, so a set output stays on
	end

	scrc_return_stack u_stack (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.st    (st.mem)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_pc         = pc_q;
	assign o_error_flag = err_q;
	assign o_depth      = st.depth;
	assign o_in_sub     = in_sub;
	assign o_edge_out   = edge_q;
endmodule

// ===== scrc_pkg.sv
// scrc_pkg.sv - constants and types for the subroutine call/return control
// Operation
// - call and entry numbers are constants from 0 to 127
// - function code 091 is call, 092 is entry, 093 is return
// - return stack nests 16 deep; a deeper call sets the error flag
// - a call to a number with no entry marker sets the error flag
// - a call to an active subroutine, itself included, sets the error flag
// - a call to a subroutine of another task sets the error flag
// - a call without any error clears the error flag
// - return resumes after the invoking call and pops one level
// - one subroutine may be called from many sites, each returning home
// - a call inside an interlocked section acts as no-operation
// - main code after the first entry marker never runs in sequence
// - a subroutine body runs only through a call, never by fall-through
// - a second pass in one scan turns edge outputs off unsampled
// - an edge output stays on when its subroutine is not called next scan
// - entry and return leave all condition flags unchanged
package scrc_pkg;
	// ------------------------------------------------------------
	// widths and sizes
	// ------------------------------------------------------------
	localparam int PC_W        = 16;
	localparam int FC_W        = 12;
	localparam int SUBN_W      = 7;
	localparam int TASK_W      = 4;
	localparam int STACK_DEPTH = 16;
	localparam int SP_W        = 5;
	localparam int NUM_SUBS    = 128;
	localparam int NUM_EDGE    = 16;
	localparam int EDGE_W      = 4;

	// ------------------------------------------------------------
	// function codes (three decimal digits held as bcd)
	// ------------------------------------------------------------
	localparam logic [FC_W-1:0] FC_NO_OPERATION = 12'h000;
	localparam logic [FC_W-1:0] FC_SUB_CALL     = 12'h091;
	localparam logic [FC_W-1:0] FC_SUB_ENTRY    = 12'h092;
	localparam logic [FC_W-1:0] FC_SUB_RETURN   = 12'h093;
	localparam logic [FC_W-1:0] FC_RISE_EDGE    = 12'h013;
	localparam logic [FC_W-1:0] FC_FALL_EDGE    = 12'h014;

	// ------------------------------------------------------------
	// limits and reset values
	// ------------------------------------------------------------
	localparam logic [SUBN_W-1:0] SUBN_MAX = 7'h7f;
	localparam logic [SP_W-1:0]   SP_FULL  = 5'h10;
	localparam logic [SP_W-1:0]   SP_EMPTY = 5'h00;
	localparam logic [PC_W-1:0]   PC_RESET = 16'h0000;

	// ------------------------------------------------------------
	// sequencer state (one-hot)
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SCRC_IDLE = 3'b001,
		SCRC_MAIN = 3'b010,
		SCRC_DONE = 3'b100
	} scrc_state_t;

	// return-stack frame
	typedef struct packed {
		logic [PC_W-1:0]   ret_pc;
		logic [SUBN_W-1:0] subn;
	} scrc_frame_t;
endpackage

// ===== scrc_stack_if.sv
// scrc_stack_if.sv - interface between sequencer and return stack memory
`timescale 1ns/10ps
interface scrc_stack_if;
	import scrc_pkg::*;
	logic                push;
	logic                pop;
	logic                clear;
	scrc_frame_t         wdata;
	scrc_frame_t         top;
	logic [SP_W-1:0]     depth;
	logic [NUM_SUBS-1:0] active;

	modport ctrl (output push, output pop, output clear, output wdata,
	              input top, input depth, input active);
	modport mem  (input push, input pop, input clear, input wdata,
	              output top, output depth, output active);
endinterface

// ===== scrc_return_stack.sv
// scrc_return_stack.sv - sixteen-deep return stack with active-subroutine map
`timescale 1ns/10ps
module scrc_return_stack
	import scrc_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_rst,
	scrc_stack_if.mem st
);
	scrc_frame_t         mem_q [STACK_DEPTH];
	logic [SP_W-1:0]     sp_q;
	logic [NUM_SUBS-1:0] act_q;
	scrc_frame_t         top_q;

	// ------------------------------------------------------------
	// frame storage and registered top of stack
	// ------------------------------------------------------------
	// write the frame at the stack pointer on push
	always_ff @(posedge i_clk) begin
		if (st.push && sp_q != SP_FULL) begin
			mem_q[sp_q[3:0]] <= st.wdata;
		end
	end

	// registered top: new frame on push, frame below on pop
	always_ff @(posedge i_clk) begin
		if (i_rst || st.clear) begin
			top_q <= '0;
		end else if (st.push && sp_q != SP_FULL) begin
			top_q <= st.wdata;
		end else if (st.pop && sp_q > 5'h01) begin
			top_q <= mem_q[4'(sp_q - 5'h02)];
		end
	end

	// ------------------------------------------------------------
	// depth and active map
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst || st.clear) begin
			sp_q  <= SP_EMPTY;
			act_q <= '0;
		end else if (st.push && sp_q != SP_FULL) begin
			sp_q                 <= sp_q + 5'h01;
			act_q[st.wdata.subn] <= 1'b1;
		end else if (st.pop && sp_q != SP_EMPTY) begin
			sp_q              <= sp_q - 5'h01;
			act_q[top_q.subn] <= 1'b0;
		end
	end

	assign st.top    = top_q;
	assign st.depth  = sp_q;
	assign st.active = act_q;
endmodule

// ===== scrc_prog_model.sv
// scrc_prog_model.sv - instruction stream of one task as fetched by the sequencer
`timescale 1ns/10ps
module scrc_prog_model
	import scrc_pkg::*;
(
	input  wire logic [PC_W-1:0]   i_pc,
	output logic [FC_W-1:0]        o_fc,
	output logic [SUBN_W-1:0]      o_subn,
	output logic [EDGE_W-1:0]      o_edge,
	output logic                   o_cond,
	output logic                   o_lock
);
	// word: lock, cond, edge index, constant number, code; the bench fills it
	logic [24:0] mem [128];
	// numbers are constants 0..127, distinct, same task, no step codes
	assign {o_lock, o_cond, o_edge, o_subn, o_fc} = mem[i_pc[6:0]];
endmodule

// ===== scrc_core_asserts.sv
// scrc_core_asserts.sv - port-level checks of the subroutine sequencer
`timescale 1ns/10ps
module scrc_core_asserts
	import scrc_pkg::*;
(
	input wire logic            i_clk,
	input wire logic            i_rst,
	input wire logic            i_task_start,
	input wire logic            i_instr_valid,
	input wire logic [FC_W-1:0] i_instr_fc,
	input wire logic            i_interlock,
	input wire logic            o_instr_ready,
	input wire logic [PC_W-1:0] o_pc,
	input wire logic            o_error_flag,
	input wire logic [SP_W-1:0] o_depth
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// instruction taken this cycle and not overridden by a restart
	wire tk      = i_instr_valid && o_instr_ready && !i_task_start;
	wire tk_call = tk && i_instr_fc == FC_SUB_CALL && !i_interlock;
	wire tk_ret  = tk && i_instr_fc == FC_SUB_RETURN;
	wire tk_end  = tk && i_instr_fc == FC_SUB_ENTRY || tk_ret;
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	chk_call_push: assert property (tk_call && o_depth != SP_FULL |=> (o_error_flag ?
		$stable(o_depth) && o_pc == $past(o_pc) + 16'h0001 : o_depth == $past(o_depth) + 5'h01))
		else $error("call neither pushed nor flagged");
	chk_deep_flag: assert property (
		tk_call && o_depth == SP_FULL |=> o_error_flag && o_depth == SP_FULL)
		else $error("call beyond sixteen levels not flagged");
	chk_ret_pop: assert property (
		tk_ret && o_depth != SP_EMPTY |=> o_depth == $past(o_depth) - 5'h01)
		else $error("return did not pop one level");
	chk_ret_empty: assert property (
		tk_ret && o_depth == SP_EMPTY |=> o_pc == $past(o_pc) + 16'h0001 && o_depth == SP_EMPTY)
		else $error("return on empty stack moved the flow");
	chk_flag_kept: assert property (tk_end |=> $stable(o_error_flag))
		else $error("entry or return changed the error flag");
	chk_lock_nop: assert property (tk && i_instr_fc == FC_SUB_CALL && i_interlock |=>
		o_pc == $past(o_pc) + 16'h0001 && $stable(o_error_flag) && $stable(o_depth))
		else $error("interlocked call did not act as no-operation");
	chk_entry_stop: assert property (
		tk && i_instr_fc == FC_SUB_ENTRY && o_depth == SP_EMPTY |=> !o_instr_ready)
		else $error("fall-through into entry marker kept running");
	chk_start_clear: assert property (
		i_task_start |=> o_pc == PC_RESET && o_depth == SP_EMPTY)
		else $error("task start left pc or stack");
	// main scenarios reached
	cover property (tk_call && o_depth == SP_FULL);
	cover property (tk_ret && o_depth != SP_EMPTY);
	cover property (tk && i_instr_fc == FC_SUB_CALL && i_interlock);
endmodule

// ===== test_subroutine_call_return_control.sv
// test_subroutine_call_return_control.sv - self-checking bench of the subroutine sequencer
`timescale 1ns/10ps
module test_subroutine_call_return_control
	import scrc_pkg::*;
;
	logic i_clk, i_rst, i_task_start, i_scan_start, i_instr_valid, i_instr_cond, i_interlock;
	logic i_def_valid, o_instr_ready, o_error_flag, o_in_sub;
	logic [TASK_W-1:0] i_task_id, i_def_task;
	logic [FC_W-1:0] i_instr_fc;
	logic [SUBN_W-1:0] i_instr_subn, i_def_subn;
	logic [EDGE_W-1:0] i_instr_edge;
	logic [PC_W-1:0] i_def_pc, o_pc;
	logic [SP_W-1:0] o_depth;
	logic [NUM_EDGE-1:0] o_edge_out;
	int mismatches, check_count, cycles;
	scrc_core i_dut (
		.i_clk         (i_clk),
		.i_rst         (i_rst),
		.i_task_start  (i_task_start),
		.i_task_id     (i_task_id),
		.i_scan_start  (i_scan_start),
		.i_instr_valid (i_instr_valid),
		.i_instr_fc    (i_instr_fc),
		.i_instr_subn  (i_instr_subn),
		.i_instr_edge  (i_instr_edge),
		.i_instr_cond  (i_instr_cond),
		.i_interlock   (i_interlock),
		.i_def_valid   (i_def_valid),
		.i_def_subn    (i_def_subn),
		.i_def_task    (i_def_task),
		.i_def_pc      (i_def_pc),
		.o_instr_ready (o_instr_ready),
		.o_pc          (o_pc),
		.o_error_flag  (o_error_flag),
		.o_depth       (o_depth),
		.o_in_sub      (o_in_sub),
		.o_edge_out    (o_edge_out)
	);
	scrc_prog_model i_prog (.i_pc(o_pc), .o_fc(i_instr_fc), .o_subn(i_instr_subn),
		.o_edge(i_instr_edge), .o_cond(i_instr_cond), .o_lock(i_interlock));
	// 40 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// cycle ceiling against a hang
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			report_and_stop();
		end
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic step();
		@(posedge i_clk);
		#2;
	endtask
	task automatic cmp(string what, logic [15:0] got, logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one instruction executes, then pc, depth and flag are judged
	task automatic walk(int pc, int dp, int er);
		step();
		cmp("pc", o_pc, pc[15:0]);
		cmp("depth", 16'(o_depth), dp[15:0]);
		cmp("error", 16'(o_error_flag), er[15:0]);
		cmp("in_sub", 16'(o_in_sub), (dp != 0) ? 16'h0001 : 16'h0000);
	endtask
	task automatic drain();
		for (int i = 0; i < 40 && o_instr_ready === 1'b1; i++) step();
		cmp("ready", 16'(o_instr_ready), 16'h0000);
	endtask
	// restart the task and run it until the entry marker stops it
	task automatic scan();
		go();
		drain();
	endtask
	task automatic put(int a, logic [FC_W-1:0] fc, int n = 0, bit lk = 0, bit cd = 0);
		i_prog.mem[a] = {lk, cd, 4'h2, n[6:0], fc};
	endtask
	// program reset to no-operation words; directory entries are kept
	task automatic clr();
		for (int i = 0; i < 128; i++) i_prog.mem[i] = '0;
	endtask
	task automatic def(int n, int t, int p);
		i_def_valid = 1'b1;
		i_def_subn = n[6:0];
		i_def_task = t[3:0];
		i_def_pc = p[15:0];
		step();
	endtask
	task automatic go();
		i_def_valid = 1'b0;
		i_task_start = 1'b1;
		i_scan_start = 1'b1;
		step();
		i_task_start = 1'b0;
		i_scan_start = 1'b0;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_two_sites();
		clr();
		put(0, FC_SUB_CALL, 5);
		put(1, FC_SUB_CALL, 5);
		put(2, FC_SUB_ENTRY, 9);
		put(12, FC_SUB_RETURN);
		def(5, 0, 10);
		go();
		walk(11, 1, 0);
		walk(12, 1, 0);
		walk(1, 0, 0);
		walk(11, 1, 0);
		walk(12, 1, 0);
		walk(2, 0, 0);
		drain();
	endtask
	task automatic t_errors();
		clr();
		put(0, FC_SUB_CALL, 3);
		put(1, FC_SUB_CALL, 5, 1);
		put(2, FC_SUB_CALL, 6);
		put(3, FC_SUB_CALL, 5);
		put(4, FC_SUB_RETURN);
		put(5, FC_SUB_ENTRY, 7);
		put(11, FC_SUB_CALL, 5);
		put(12, FC_SUB_RETURN);
		def(5, 0, 10);
		def(6, 2, 20);
		go();
		walk(1, 0, 1);
		walk(2, 0, 1);
		walk(3, 0, 1);
		walk(11, 1, 0);
		walk(12, 1, 1);
		walk(4, 0, 1);
		walk(5, 0, 1);
		drain();
		cmp("error", 16'(o_error_flag), 16'h0001);
	endtask
	task automatic t_deep();
		clr();
		put(0, FC_SUB_CALL, 0);
		put(1, FC_SUB_ENTRY, 127);
		for (int k = 0; k <= 16; k++) begin
			put(20 + 3 * k, FC_SUB_ENTRY, k);
			put(21 + 3 * k, FC_SUB_CALL, k + 1);
			put(22 + 3 * k, FC_SUB_RETURN);
			def(k, 0, 20 + 3 * k);
		end
		go();
		for (int k = 0; k < 16; k++) walk(21 + 3 * k, k + 1, 0);
		walk(67, 16, 1);
		for (int k = 15; k > 0; k--) walk(19 + 3 * k, k, 1);
		walk(1, 0, 1);
		drain();
	endtask
	task automatic t_edges();
		clr();
		put(0, FC_SUB_CALL, 5);
		put(1, FC_SUB_CALL, 5);
		put(2, FC_SUB_ENTRY, 9);
		put(11, FC_RISE_EDGE);
		put(12, FC_SUB_RETURN);
		def(5, 0, 10);
		go();
		walk(11, 1, 0);
		walk(12, 1, 0);
		walk(1, 0, 0);
		put(11, FC_RISE_EDGE, 0, 0, 1);
		walk(11, 1, 0);
		walk(12, 1, 0);
		cmp("edge", 16'(o_edge_out[2]), 16'h0000);
		put(1, FC_NO_OPERATION);
		scan();
		cmp("edge", 16'(o_edge_out[2]), 16'h0001);
		put(0, FC_NO_OPERATION);
		scan();
		cmp("edge", 16'(o_edge_out[2]), 16'h0001);
		// falling form: input still high turns it off, a drop turns it on
		put(0, FC_SUB_CALL, 5);
		put(11, FC_FALL_EDGE, 0, 0, 1);
		scan();
		cmp("edge", 16'(o_edge_out[2]), 16'h0000);
		put(11, FC_FALL_EDGE);
		scan();
		cmp("edge", 16'(o_edge_out[2]), 16'h0001);
	endtask
	// reset after a finished run clears outputs and the entry directory
	task automatic t_reset();
		clr();
		put(0, FC_SUB_CALL, 5);
		put(1, FC_SUB_ENTRY, 5);
		i_rst = 1'b1;
		repeat (2) step();
		i_rst = 1'b0;
		cmp("edge", o_edge_out, 16'h0000);
		cmp("ready", 16'(o_instr_ready), 16'h0000);
		go();
		walk(1, 0, 1);
		drain();
	endtask
	task automatic report_and_stop();
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// reset for twenty cycles, then the scenarios in turn
	initial begin
		{i_task_start, i_scan_start, i_def_valid, i_task_id, i_def_subn, i_def_task} = '0;
		i_def_pc = '0;
		i_rst = 1'b1;
		i_instr_valid = 1'b1;
		repeat (20) step();
		i_rst = 1'b0;
		t_two_sites();
		t_errors();
		t_deep();
		t_edges();
		t_reset();
		report_and_stop();
	end
endmodule
bind scrc_core scrc_core_asserts u_chk (
	.i_clk         (i_clk),
	.i_rst         (i_rst),
	.i_task_start  (i_task_start),
	.i_instr_valid (i_instr_valid),
	.i_instr_fc    (i_instr_fc),
	.i_interlock   (i_interlock),
	.o_instr_ready (o_instr_ready),
	.o_pc          (o_pc),
	.o_error_flag  (o_error_flag),
	.o_depth       (o_depth)
);
